// ===== lcd_cmd_drive.v
// LCD command interpreter with column and row panel drive generator
`timescale 1ns/1ns
`include "lcd_cmd_regs.vh"

// Functional notes
// - Code 40h initializes, eight parameter bytes follow
// - Code 53h standby; drive-active falls at a frame end
// - Codes 58h/59h switch display, one parameter
// - Code 44h takes ten start/region parameter bytes
// - Codes 5Ch/5Dh each take two bytes
// - Codes 4Ch-4Fh set cursor direction, no parameters
// - Code 5Ah takes one pixel shift byte
// - Code 5Bh takes one layer combine byte
// - Cursor set/get bytes handled individually
// - Codes 42h/43h stream unlimited data bytes
// - Unpaired parameter bytes update registers on arrival
// - New command may cut parameters short
// - Paired bytes commit together, lone byte dropped
// - Address pitch bytes act independently
// - Nibble data captured on shift clock fall
// - Shift clock halts from latch to line
// - Enable chain clock falls every 16 pulses
// - Line latch pulses once per line
// - Row scan pulse during last line
// - Drive-active high while drive outputs active
// - AC waveform period one of two values
// - Select 0 is 32 lines, 1 two frames
module lcd_cmd_drive (
  // Clock and reset
  input wire clock_i,
  input wire arst_n_i,
  // Host port
  input wire addr_i,
  input wire [7:0] wdata_i,
  input wire wr_i,
  input wire rd_i,
  output reg [7:0] rdata_o,
  // Panel drive
  output reg [3:0] column_data_o,
  output reg column_shift_clock_o,
  output reg column_enable_chain_clock_o,
  output reg line_latch_pulse_o,
  output reg ac_drive_waveform_o,
  output reg row_shift_clock_o,
  output reg row_scan_pulse_o,
  output reg display_drive_active_o
);

  // Timing generator states
  localparam ST_IDLE = 2'b00;
  localparam ST_SHIFT = 2'b01;
  localparam ST_LATCH = 2'b10;

  integer i;

  // Command context and parameter storage
  reg [7:0] cmd_q;
  reg [3:0] pidx_q;
  reg [7:0] init_q [0:7];
  reg [7:0] scroll_q [0:9];
  reg [7:0] pend_q;
  reg pend_v_q;
  reg [7:0] dswitch_q;
  reg [15:0] glyph_q;
  reg [15:0] cshape_q;
  reg [1:0] cdir_q;
  reg [7:0] pshift_q;
  reg [7:0] layer_q;
  reg [15:0] cursor_q;
  reg disp_on_q;
  reg sleep_q;
  reg init_seen_q;
  reg restart_q;

  // Timing state
  reg [1:0] state_q;
  reg phase_q;
  reg [8:0] nib_q;
  reg [3:0] ecl_q;
  reg [1:0] lp_q;
  reg [7:0] line_q;
  reg [3:0] wf_cnt_q;

  // Decoded host events
  wire cmd_wr = wr_i && (addr_i == `A_CMD);
  wire dat_wr = wr_i && (addr_i == `A_DATA);
  wire dat_rd = rd_i && (addr_i == `A_DATA);
  wire is_cdir = ((wdata_i & `CMD_CDIR_MASK) == `CMD_CDIR);
  wire known = (wdata_i == `CMD_INIT) || (wdata_i == `CMD_STANDBY) ||
               (wdata_i == `CMD_DISP_OFF) || (wdata_i == `CMD_DISP_ON) ||
               (wdata_i == `CMD_SCROLL) || (wdata_i == `CMD_GLYPH) ||
               (wdata_i == `CMD_CSHAPE) || is_cdir ||
               (wdata_i == `CMD_PSHIFT) || (wdata_i == `CMD_LAYER) ||
               (wdata_i == `CMD_CSET) || (wdata_i == `CMD_CGET) ||
               (wdata_i == `CMD_MSTORE) || (wdata_i == `CMD_MFETCH);

  // Parameter count of the running command
  reg [3:0] nparam;
  always @* begin
    case (cmd_q)
      `CMD_INIT: nparam = `NP_INIT;
      `CMD_SCROLL: nparam = `NP_SCROLL;
      `CMD_GLYPH, `CMD_CSHAPE, `CMD_CSET, `CMD_CGET: nparam = `NP_TWO;
      `CMD_DISP_OFF, `CMD_DISP_ON: nparam = `NP_ONE;
      `CMD_PSHIFT, `CMD_LAYER: nparam = `NP_ONE;
      default: nparam = `NP_ZERO;
    endcase
  end

  wire in_range = (pidx_q < nparam);
  wire [15:0] pitch = {init_q[`IP_APH], init_q[`IP_APL]};

  // Next cursor address after one streamed data byte
  reg [15:0] cur_step;
  always @* begin
    case (cdir_q)
      `DIR_RIGHT: cur_step = cursor_q + 16'h0001;
      `DIR_LEFT: cur_step = cursor_q - 16'h0001;
      `DIR_UP: cur_step = cursor_q - pitch;
      `DIR_DOWN: cur_step = cursor_q + pitch;
      default: cur_step = cursor_q;
    endcase
  end

  // Scroll high bytes close an address pair
  wire sc_hi = (pidx_q == 4'h1) || (pidx_q == 4'h4) ||
               (pidx_q == 4'h7) || (pidx_q == 4'h9);
  wire sc_lo = (pidx_q == 4'h0) || (pidx_q == 4'h3) ||
               (pidx_q == 4'h6) || (pidx_q == 4'h8);

  // Command decode and parameter capture
  always @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      cmd_q <= `CMD_NONE;
      pidx_q <= 4'h0;
      for (i = 0; i < 8; i = i + 1) begin
        init_q[i] <= `RESET_VAL;
      end
      for (i = 0; i < 10; i = i + 1) begin
        scroll_q[i] <= `RESET_VAL;
      end
      pend_q <= `RESET_VAL;
      pend_v_q <= 1'b0;
      dswitch_q <= `RESET_VAL;
      glyph_q <= 16'h0000;
      cshape_q <= 16'h0000;
      cdir_q <= `DIR_RIGHT;
      pshift_q <= `RESET_VAL;
      layer_q <= `RESET_VAL;
      cursor_q <= 16'h0000;
      disp_on_q <= 1'b0;
      sleep_q <= 1'b0;
      init_seen_q <= 1'b0;
      restart_q <= 1'b0;
    end else begin
      restart_q <= 1'b0;
      if (cmd_wr && known) begin
        // A new command drops any half-received pair
        cmd_q <= wdata_i;
        pidx_q <= 4'h0;
        pend_v_q <= 1'b0;
        case (wdata_i)
          `CMD_INIT: begin
            sleep_q <= 1'b0;
            disp_on_q <= 1'b0;
            init_seen_q <= 1'b1;
            restart_q <= 1'b1;
          end
          `CMD_STANDBY: sleep_q <= 1'b1;
          `CMD_DISP_OFF: disp_on_q <= 1'b0;
          `CMD_DISP_ON: disp_on_q <= 1'b1;
          default: begin
            if (is_cdir) begin
              cdir_q <= wdata_i[1:0];
            end
          end
        endcase
      end else if (dat_wr && (cmd_q == `CMD_MSTORE)) begin
        cursor_q <= cur_step;
      end else if (dat_rd && (cmd_q == `CMD_MFETCH)) begin
        cursor_q <= cur_step;
      end else if (dat_rd && (cmd_q == `CMD_CGET) && in_range) begin
        pidx_q <= pidx_q + 4'h1;
      end else if (dat_wr && in_range) begin
        pidx_q <= pidx_q + 4'h1;
        case (cmd_q)
          // Init bytes land at once; pitch bytes too
          `CMD_INIT: init_q[pidx_q[2:0]] <= wdata_i;
          `CMD_SCROLL: begin
            if (sc_lo) begin
              pend_q <= wdata_i;
              pend_v_q <= 1'b1;
            end else if (sc_hi) begin
              if (pend_v_q) begin
                scroll_q[pidx_q - 4'h1] <= pend_q;
                scroll_q[pidx_q] <= wdata_i;
              end
              pend_v_q <= 1'b0;
            end else begin
              scroll_q[pidx_q] <= wdata_i;
            end
          end
          `CMD_GLYPH: begin
            if (pidx_q == 4'h0) begin
              pend_q <= wdata_i;
              pend_v_q <= 1'b1;
            end else if (pend_v_q) begin
              glyph_q <= {wdata_i, pend_q};
              pend_v_q <= 1'b0;
            end
          end
          `CMD_CSHAPE: begin
            if (pidx_q == 4'h0) begin
              cshape_q[7:0] <= wdata_i;
            end else begin
              cshape_q[15:8] <= wdata_i;
            end
          end
          `CMD_CSET: begin
            if (pidx_q == 4'h0) begin
              cursor_q[7:0] <= wdata_i;
            end else begin
              cursor_q[15:8] <= wdata_i;
            end
          end
          `CMD_DISP_OFF, `CMD_DISP_ON: dswitch_q <= wdata_i;
          `CMD_PSHIFT: pshift_q <= wdata_i;
          `CMD_LAYER: layer_q <= wdata_i;
          default: pshift_q <= pshift_q;
        endcase
      end
    end
  end

  // Read data, valid only in the cycle after the strobe
  always @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      rdata_o <= `RESET_VAL;
    end else if (rd_i && (addr_i == `A_CMD)) begin
      rdata_o <= {display_drive_active_o, sleep_q, disp_on_q, 5'h00};
    end else if (dat_rd && (cmd_q == `CMD_CGET) && in_range) begin
      rdata_o <= (pidx_q == 4'h0) ? cursor_q[7:0] : cursor_q[15:8];
    end else begin
      rdata_o <= `RESET_VAL;
    end
  end

  // Timing parameters from initialization
  wire [8:0] nib_last = {init_q[`IP_CR], 1'b1};
  wire [7:0] line_last = init_q[`IP_LF];
  wire wf_two_frame = init_q[`IP_WF_BYTE][`IP_WF_BIT];
  wire frame_end = (state_q == ST_LATCH) && (lp_q == 2'h1) &&
                   (line_q == line_last);
  wire run_ok = init_seen_q && !restart_q;

  // Panel timing generator
  always @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      state_q <= ST_IDLE;
      phase_q <= 1'b0;
      nib_q <= 9'h000;
      ecl_q <= 4'h0;
      lp_q <= 2'h0;
      line_q <= 8'h00;
      wf_cnt_q <= 4'h0;
      column_data_o <= 4'h0;
      column_shift_clock_o <= 1'b0;
      column_enable_chain_clock_o <= 1'b0;
      line_latch_pulse_o <= 1'b0;
      ac_drive_waveform_o <= 1'b0;
      row_shift_clock_o <= 1'b0;
      row_scan_pulse_o <= 1'b0;
      display_drive_active_o <= 1'b0;
    end else if (!run_ok) begin
      // Initialization restarts the generator from line zero
      state_q <= ST_IDLE;
      phase_q <= 1'b0;
      nib_q <= 9'h000;
      ecl_q <= 4'h0;
      lp_q <= 2'h0;
      line_q <= 8'h00;
      wf_cnt_q <= 4'h0;
      column_data_o <= 4'h0;
      column_shift_clock_o <= 1'b0;
      column_enable_chain_clock_o <= 1'b0;
      line_latch_pulse_o <= 1'b0;
      row_shift_clock_o <= 1'b0;
      row_scan_pulse_o <= 1'b0;
      display_drive_active_o <= 1'b0;
    end else begin
      case (state_q)
        ST_IDLE: begin
          if (!sleep_q) begin
            state_q <= ST_SHIFT;
            display_drive_active_o <= 1'b1;
          end
        end
        ST_SHIFT: begin
          phase_q <= ~phase_q;
          column_shift_clock_o <= ~phase_q;
          if (!phase_q) begin
            // Data changes on the rising edge, stable at the fall
            column_data_o <= disp_on_q ? (nib_q[3:0] ^ layer_q[3:0]) : 4'h0;
            column_enable_chain_clock_o <= (ecl_q == `ECL_LAST);
          end else begin
            nib_q <= nib_q + 9'h001;
            ecl_q <= ecl_q + 4'h1;
            column_enable_chain_clock_o <= 1'b0;
            if (nib_q == nib_last) begin
              state_q <= ST_LATCH;
              lp_q <= `LP_CYC;
              line_latch_pulse_o <= 1'b1;
              row_shift_clock_o <= 1'b1;
            end
          end
        end
        ST_LATCH: begin
          // Shift clock stays low for the whole latch phase
          column_shift_clock_o <= 1'b0;
          lp_q <= lp_q - 2'h1;
          if (lp_q == 2'h1) begin
            line_latch_pulse_o <= 1'b0;
            row_shift_clock_o <= 1'b0;
            nib_q <= 9'h000;
            ecl_q <= 4'h0;
            phase_q <= 1'b0;
            wf_cnt_q <= wf_cnt_q + 4'h1;
            if (!wf_two_frame && (wf_cnt_q == `WF_LAST)) begin
              ac_drive_waveform_o <= ~ac_drive_waveform_o;
            end
            if (frame_end) begin
              line_q <= 8'h00;
              if (wf_two_frame) begin
                ac_drive_waveform_o <= ~ac_drive_waveform_o;
              end
              if (sleep_q) begin
                // Standby takes effect at a frame boundary
                state_q <= ST_IDLE;
                display_drive_active_o <= 1'b0;
                row_scan_pulse_o <= 1'b0;
              end else begin
                state_q <= ST_SHIFT;
                row_scan_pulse_o <= (line_last == 8'h00);
              end
            end else begin
              line_q <= line_q + 8'h01;
              state_q <= ST_SHIFT;
              row_scan_pulse_o <= ((line_q + 8'h01) == line_last);
            end
          end
        end
        default: state_q <= ST_IDLE;
      endcase
    end
  end

endmodule

// ===== lcd_cmd_drive_checker.sv
// Port assertions for the LCD command and panel drive block
`timescale 1ns/1ns
module lcd_cmd_drive_checker (
  // Clock and reset
  input wire clock_i,
  input wire arst_n_i,
  // Host port
  input wire addr_i,
  input wire [7:0] wdata_i,
  input wire wr_i,
  input wire rd_i,
  input wire [7:0] rdata_o,
  // Panel drive
  input wire [3:0] column_data_o,
  input wire column_shift_clock_o,
  input wire column_enable_chain_clock_o,
  input wire line_latch_pulse_o,
  input wire ac_drive_waveform_o,
  input wire row_shift_clock_o,
  input wire row_scan_pulse_o,
  input wire display_drive_active_o
);
  default clocking @(posedge clock_i); endclocking
  default disable iff (!arst_n_i);
  // Read data is only valid in the cycle after the strobe
  a_rdata_one_cycle: assert property (!$past(rd_i) |-> rdata_o == 8'h00)
    else $error("read data outside its cycle");
  // Init restarts the generator and may cut a pulse short
  wire init_wr = wr_i && addr_i && (wdata_i == 8'h40);
  a_latch_two_cycles: assert property ($rose(line_latch_pulse_o) && !$past(init_wr) |=>
    line_latch_pulse_o ##1 !line_latch_pulse_o) else $error("latch pulse width wrong");
  // Shift clock parked low while the line latches, saving power
  a_shift_halted: assert property (line_latch_pulse_o |-> !column_shift_clock_o)
    else $error("shift clock runs during latch");
  a_data_at_fall: assert property ($fell(column_shift_clock_o) |-> $stable(column_data_o))
    else $error("column data moves at shift fall");
  a_row_clock_latch: assert property (row_shift_clock_o == line_latch_pulse_o)
    else $error("row clock out of step with latch");
  a_drive_outputs: assert property (column_shift_clock_o || line_latch_pulse_o
    |-> display_drive_active_o) else $error("drive runs while inactive");
  a_standby_drop: assert property (wr_i && addr_i && wdata_i == 8'h53
    |-> ##[1:1000] !display_drive_active_o) else $error("standby did not stop drive");
  a_chain_short: assert property ($rose(column_enable_chain_clock_o)
    |=> !column_enable_chain_clock_o) else $error("chain clock high too long");
  c_standby: cover property ($fell(display_drive_active_o));
  c_frame: cover property ($rose(row_scan_pulse_o));
  c_ac: cover property ($changed(ac_drive_waveform_o));
endmodule

bind lcd_cmd_drive lcd_cmd_drive_checker i_lcd_cmd_drive_checker (.clock_i, .arst_n_i,
  .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o, .column_data_o, .column_shift_clock_o,
  .column_enable_chain_clock_o, .line_latch_pulse_o, .ac_drive_waveform_o,
  .row_shift_clock_o, .row_scan_pulse_o, .display_drive_active_o);

// ===== lcd_cmd_drive_tb.sv
// Self-checking bench for the LCD command and panel drive block
`timescale 1ns/1ns
`include "lcd_cmd_regs.vh"
module lcd_cmd_drive_tb;
  reg clock_i = 1'b0;
  reg arst_n_i = 1'b0;
  wire addr_i;
  wire wr_i;
  wire rd_i;
  wire [7:0] wdata_i;
  wire [7:0] rdata_o;
  wire [3:0] column_data_o;
  wire [4:0] ev;
  wire display_drive_active_o;
  int n_fail = 0;
  int n_checks = 0;
  int evc [0:4] = '{0, 0, 0, 0, 0};
  int s [0:4];
  reg [4:0] prev_q = 5'h00;
  reg [15:0] v;
  always #2 clock_i = ~clock_i;
  lcd_cmd_drive i_lcd_cmd_drive (.clock_i, .arst_n_i, .addr_i, .wdata_i, .wr_i, .rd_i,
    .rdata_o, .column_data_o, .line_latch_pulse_o(ev[0]), .column_shift_clock_o(ev[1]),
    .column_enable_chain_clock_o(ev[2]), .row_scan_pulse_o(ev[3]),
    .ac_drive_waveform_o(ev[4]), .row_shift_clock_o(), .display_drive_active_o);
  lcd_host_model i_lcd_host_model (.clock_i, .addr_o(addr_i), .wdata_o(wdata_i),
    .wr_o(wr_i), .rd_o(rd_i), .rdata_i(rdata_o));
  // Edge counters for latch, shift, chain, row scan; any AC change
  always @(posedge clock_i) begin
    prev_q <= ev;
    for (int k = 0; k < 4; k++) if (ev[k] && !prev_q[k]) evc[k] <= evc[k] + 1;
    if (ev[4] !== prev_q[4]) evc[4] <= evc[4] + 1;
  end
  task final_report;
    begin
      $display("checks %0d mismatches %0d", n_checks, n_fail);
      if (n_fail == 0 && n_checks > 0)
        $display("ALL TESTS PASSED");
      else
        $display("TESTS FAILED");
      $finish;
    end
  endtask
  task chk(input string nm, input [15:0] exp, input [15:0] got);
    begin
      n_checks++;
      if (got !== exp) begin
        n_fail++;
        $display("wrong value %s expected %h seen %h", nm, exp, got);
      end
    end
  endtask
  // Bounded waits; running out ends the run as a mismatch
  task wait_ev(input int k);
    int n0;
    int t;
    begin
      n0 = evc[k];
      for (t = 0; t < 5000 && evc[k] == n0; t++) @(posedge clock_i);
      chk("event seen", 16'h0001, {15'h0000, evc[k] != n0});
      if (evc[k] == n0) final_report;
    end
  endtask
  task wait_act(input b);
    int t;
    begin
      for (t = 0; t < 1000 && display_drive_active_o !== b; t++) @(posedge clock_i);
      chk("drive active", {15'h0000, b}, {15'h0000, display_drive_active_o});
      if (display_drive_active_o !== b) final_report;
    end
  endtask
  function [15:0] dl(input int k);
    dl = 16'(evc[k] - s[k]);
  endfunction
  task wc(input [7:0] d);
    i_lcd_host_model.put(1'b1, d);
  endtask
  task wp(input [7:0] d);
    i_lcd_host_model.put(1'b0, d);
  endtask
  task st(input [7:0] exp);
    begin
      i_lcd_host_model.get(1'b1, v[7:0]);
      chk("status", {8'h00, exp}, {8'h00, v[7:0]});
    end
  endtask
  task cur(input [15:0] exp);
    begin
      wc(`CMD_CGET);
      i_lcd_host_model.get(1'b0, v[7:0]);
      i_lcd_host_model.get(1'b0, v[15:8]);
      chk("cursor", exp, v);
    end
  endtask
  // Frame of 4 lines, 32 shift pulses a line
  task t_drive;
    begin
      i_lcd_host_model.init_seq(1'b1, 8'h10, 8);
      wait_act(1'b1);
      wait_ev(3);
      s = evc;
      wait_ev(3);
      chk("lines", 16'h0004, dl(0));
      chk("shift", 16'h0080, dl(1));
      chk("chain", 16'h0008, dl(2));
      $display("drive done");
    end
  endtask
  // First toggles skipped: timing restart may cut a period short
  task t_ac(input wf);
    begin
      i_lcd_host_model.init_seq(wf, 8'h10, 8);
      wait_ev(4);
      wait_ev(4);
      s = evc;
      wait_ev(4);
      chk("ac lines", wf ? 16'h0004 : 16'h0010, dl(0));
      $display("ac done");
    end
  endtask
  task t_regs;
    begin
      st(8'h80);
      wc(`CMD_DISP_ON);
      wp(8'h14);
      st(8'hA0);
      wc(`CMD_DISP_OFF);
      wp(8'h14);
      st(8'h80);
      wc(`CMD_CSET);
      wp(8'h34);
      wc(8'h41);
      wp(8'h12);
      cur(16'h1234);
      wc(`CMD_CSET);
      wp(8'h55);
      cur(16'h1255);
      foreach (v[i]) if (i < 5) begin
        wc(i == 0 ? `CMD_SCROLL : 8'h5A + 8'(i - 1));
        repeat (3) wp(8'h01);
      end
      // Layer byte 01 flips the low bit of every column nibble
      wc(`CMD_DISP_ON);
      wait_ev(0);
      for (int t = 0; t < 8 && ev[1] !== 1'b1; t++) @(posedge clock_i);
      chk("shift start", 16'h0001, {15'h0000, ev[1]});
      if (ev[1] !== 1'b1) final_report;
      chk("column data", 16'h0001, {12'h000, column_data_o});
      wc(`CMD_DISP_OFF);
      cur(16'h1255);
      $display("registers done");
    end
  endtask
  // Four directions with pitch 0010, then a fetch
  task t_store;
    reg [15:0] step [0:3];
    begin
      step = '{16'h0001, 16'hFFFF, 16'hFFF0, 16'h0010};
      for (int d = 0; d < 4; d++) begin
        wc(`CMD_CSET);
        wp(8'h00);
        wp(8'h01);
        wc(`CMD_CDIR | {6'h00, d[1:0]});
        wc(`CMD_MSTORE);
        wp(8'hAA);
        wp(8'h55);
        cur(16'h0100 + step[d] + step[d]);
      end
      wc(`CMD_CDIR);
      wc(`CMD_CSET);
      wp(8'h00);
      wp(8'h01);
      wc(`CMD_MFETCH);
      i_lcd_host_model.get(1'b0, v[7:0]);
      i_lcd_host_model.get(1'b0, v[7:0]);
      cur(16'h0102);
      i_lcd_host_model.init_seq(1'b1, 8'h05, 7);
      wc(8'h4F);
      wc(`CMD_CSET);
      wp(8'h00);
      wp(8'h01);
      wc(`CMD_MSTORE);
      wp(8'hAA);
      cur(16'h0105);
      $display("store done");
    end
  endtask
  task t_standby;
    begin
      wc(`CMD_STANDBY);
      wait_act(1'b0);
      st(8'h40);
      s = evc;
      repeat (200) @(posedge clock_i);
      chk("idle shift", 16'h0000, dl(1));
      i_lcd_host_model.init_seq(1'b1, 8'h10, 8);
      wait_act(1'b1);
      st(8'h80);
      $display("standby done");
    end
  endtask
  initial begin
    repeat (16) @(posedge clock_i);
    arst_n_i <= 1'b1;
    t_drive;
    t_ac(1'b0);
    t_ac(1'b1);
    t_regs;
    t_store;
    t_standby;
    final_report;
  end
endmodule

// ===== lcd_cmd_regs.vh
// Command codes, parameter layout and timing constants for the LCD command block
`ifndef LCD_CMD_REGS_VH
`define LCD_CMD_REGS_VH

// Command byte codes
`define CMD_INIT      8'h40
`define CMD_STANDBY   8'h53
`define CMD_DISP_OFF  8'h58
`define CMD_DISP_ON   8'h59
`define CMD_SCROLL    8'h44
`define CMD_GLYPH     8'h5C
`define CMD_CSHAPE    8'h5D
`define CMD_CDIR_MASK 8'hFC
`define CMD_CDIR      8'h4C
`define CMD_PSHIFT    8'h5A
`define CMD_LAYER     8'h5B
`define CMD_CSET      8'h46
`define CMD_CGET      8'h47
`define CMD_MSTORE    8'h42
`define CMD_MFETCH    8'h43
`define CMD_NONE      8'h00

// Parameter byte counts
`define NP_INIT   4'h8
`define NP_SCROLL 4'hA
`define NP_TWO    4'h2
`define NP_ONE    4'h1
`define NP_ZERO   4'h0

// Initialize parameter positions
`define IP_WF_BYTE 3'h1
`define IP_WF_BIT  7
`define IP_CR      3'h3
`define IP_LF      3'h5
`define IP_APL     3'h6
`define IP_APH     3'h7

// Cursor direction codes
`define DIR_RIGHT 2'h0
`define DIR_LEFT  2'h1
`define DIR_UP    2'h2
`define DIR_DOWN  2'h3

// Host port address values
`define A_DATA 1'b0
`define A_CMD  1'b1

// Status byte bit positions
`define ST_ACTIVE 7
`define ST_SLEEP  6
`define ST_DISPON 5

// Panel timing
`define LP_CYC    2'h2
`define ECL_LAST  4'hF
`define WF_LAST   4'hF
`define RESET_VAL 8'h00

`endif

// ===== lcd_host_model.sv
// Host processor model for the command and data port
`timescale 1ns/1ns
module lcd_host_model (
  // Clock
  input wire clock_i,
  // Host port
  output reg addr_o = 1'b0,
  output reg [7:0] wdata_o = 8'h00,
  output reg wr_o = 1'b0,
  output reg rd_o = 1'b0,
  input wire [7:0] rdata_i
);
  // One-cycle write; released data bus shows no stale byte
  task put(input a, input [7:0] d);
    begin
      @(posedge clock_i);
      addr_o <= a;
      wdata_o <= d;
      wr_o <= 1'b1;
      @(posedge clock_i);
      wr_o <= 1'b0;
      wdata_o <= ~d;
    end
  endtask
  // One-cycle read, data taken in the following cycle
  task get(input a, output [7:0] d);
    begin
      @(posedge clock_i);
      addr_o <= a;
      rd_o <= 1'b1;
      @(posedge clock_i);
      rd_o <= 1'b0;
      @(posedge clock_i);
      d = rdata_i;
    end
  endtask
  // Setup sequence; a short count leaves later bytes untouched
  task init_seq(input wf, input [7:0] apl, input int n);
    reg [7:0] p [0:7];
    int i;
    begin
      p = '{8'h30, {wf, 7'h07}, 8'h07, 8'h0F, 8'h10, 8'h03, apl, 8'h00};
      put(1'b1, 8'h40);
      for (i = 0; i < n; i++) put(1'b0, p[i]);
    end
  endtask
endmodule
